// ---- monitor_regs_pkg.sv ----
// Constants for the monitor debug configuration and fault address block.
// Assumes one core clock and a synchronous warm reset around it.
package monitor_regs_pkg;

    // Privilege levels of the requesting code
    typedef enum logic [1:0] {
        LVL_USER   = 2'h0,
        LVL_KERNEL = 2'h1,
        LVL_HYP    = 2'h2,
        LVL_MON    = 2'h3
    } level_t;

    // Form of a performance monitor register access
    typedef enum logic [1:0] {
        ACC_SYS64   = 2'h0,
        ACC_MOVE32  = 2'h1,
        ACC_MOVE2X  = 2'h2
    } pmu_acc_t;

    // Encoding fields, packed as {op0, op1, CRn, CRm, op2}
    localparam logic [1:0]  OP0_SYS = 2'h3;
    localparam logic [2:0]  OP1_MON = 3'h6;
    localparam logic [3:0]  CRN_CFG = 4'h1;
    localparam logic [3:0]  CRM_CFG = 4'h3;
    localparam logic [2:0]  OP2_CFG = 3'h1;
    localparam logic [3:0]  CRN_FA  = 4'h6;
    localparam logic [3:0]  CRM_FA  = 4'h0;
    localparam logic [2:0]  OP2_FA  = 3'h5;
    localparam logic [15:0] ENC_CFG =
        {OP0_SYS, OP1_MON, CRN_CFG, CRM_CFG, OP2_CFG};
    localparam logic [15:0] ENC_FA  =
        {OP0_SYS, OP1_MON, CRN_FA, CRM_FA, OP2_FA};

    // Configuration register field positions
    localparam int CFG_W          = 7;
    localparam int PERF_TRAP_BIT  = 6;
    localparam int DBG_EXT_BIT    = 4;
    localparam int TRC_EXT_BIT    = 3;
    localparam int PERF_EXT_BIT   = 2;
    localparam int ROOT_TRACE_BIT = 1;
    localparam int REALM_TRC_BIT  = 0;
    localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;

    // Fault address register field positions
    localparam int FA_NS_BIT  = 63;
    localparam int FA_NSE_BIT = 62;
    localparam int FA_LPA_HI  = 51;
    localparam int FA_LPA_LO  = 48;
    localparam int FA_PA_HI   = 47;
    localparam int FA_PA_LO   = 12;
    localparam int FA_PA_W    = FA_LPA_HI - FA_PA_LO + 1;
    localparam logic [FA_PA_W-1:0] FA_PA_RESET = 40'h00_0000_0000;

    // Exception classes reported for trapped accesses
    localparam logic [5:0] EC_SYSREG64 = 6'h18;
    localparam logic [5:0] EC_MOVE32   = 6'h03;
    localparam logic [5:0] EC_MOVE2X   = 6'h04;
    localparam logic [5:0] EC_NONE     = 6'h00;

endpackage

// ---- sysreg_decode.sv ----
// Decodes a system register access onto this block's two registers.
// Assumes the encoding and level are stable while valid is high.
`timescale 1ns/1ps
module sysreg_decode
    import monitor_regs_pkg::*;
#(
    parameter bit REALM_MGMT_FEATURE = 1'b1
) (
    input  wire logic                    valid,
    input  wire logic [15:0]             enc,
    input  wire monitor_regs_pkg::level_t level,
    output logic                         hitCfg,
    output logic                         hitFault,
    output logic                         undef
);
    import monitor_regs_pkg::*;

    wire isCfg   = valid && (enc == ENC_CFG);
    wire isFault = valid && (enc == ENC_FA) && REALM_MGMT_FEATURE;
    wire atMon   = (level == LVL_MON);

    assign hitCfg   = isCfg && atMon;
    // fault register only at monitor level
    assign hitFault = isFault && atMon;
    assign undef    = (isCfg && !atMon) ||
                      (valid && (enc == ENC_FA) &&
                       (!REALM_MGMT_FEATURE || !atMon));
endmodule

// ---- monitor_debug_regs.sv ----
// Monitor debug configuration and protection fault address registers.
// Assumes one core clock, synchronous warm reset and a request port
// that holds a system register access for a single cycle.
`timescale 1ns/1ps
// Behaviour
// - Trap bit set traps lower-level monitor accesses
// - Trap bit clear traps nothing
// - 64-bit trapped access reports class 0x18
// - 32-bit moves report class 0x03 or 0x04
// - Trap bit 6, zero without monitor unit
// - Bit 4 restricts debugger breakpoint access
// - Bit 3 restricts debugger trace access
// - Bit 2 restricts debugger performance access
// - Root trace prohibited when bit 1 clear
// - Realm trace prohibited when bit 0 clear
// - Trace bits set debugger authentication level
// - Config register accessible only at monitor level
// - 64-bit register captures fault physical address
// - Fault register undefined without realm feature
// - Bits 63,62 encode faulting address space
// - Bits 47:12 hold address, excess zero
// - Bits 51:48 only with large addresses
// - Monitor exception return clears fault register
// - Fault register accessible only at monitor level
module monitor_debug_regs
    import monitor_regs_pkg::*;
#(
    parameter bit PERF_MON_FEATURE     = 1'b1,
    parameter bit REALM_MGMT_FEATURE   = 1'b1,
    parameter bit LARGE_PA_FEATURE     = 1'b1,
    parameter bit TRACE_FILTER_FEATURE = 1'b1,
    parameter bit TRACE_BUFFER_FEATURE = 1'b1,
    parameter bit EXT_TRACE_IF         = 1'b1,
    parameter bit EXT_PERF_IF          = 1'b1,
    parameter int PA_WIDTH             = 52
) (
    input  wire logic                      clk_sys,
    input  wire logic                      nrst,
    // System register access
    input  wire logic                      regReq,
    input  wire logic                      regWrite,
    input  wire logic [15:0]               regEnc,
    input  wire monitor_regs_pkg::level_t  regLevel,
    input  wire logic [63:0]               regWdata,
    output logic                           regAck_q,
    output logic                           regUndef_q,
    output logic                           regClaim_q,
    output logic [63:0]                    regRdata_q,
    // Performance monitor register access check
    input  wire logic                      pmuReq,
    input  wire monitor_regs_pkg::level_t  pmuLevel,
    input  wire monitor_regs_pkg::pmu_acc_t pmuForm,
    input  wire logic                      hypPerfTrap,
    output logic                           pmuDone_q,
    output logic                           pmuTrap_q,
    output logic [5:0]                     pmuClass_q,
    // Granule protection fault capture
    input  wire logic                      gpcFault,
    input  wire logic [51:0]               gpcAddr,
    input  wire logic                      gpcNonSecure,
    input  wire logic                      gpcSpaceExt,
    input  wire logic                      monEret,
    // External debugger access control
    input  wire logic                      extDebugAccessDisable,
    input  wire logic                      extTraceAccessDisable,
    input  wire logic                      extPerfAccessDisable,
    output logic [1:0]                     extDebugLevel_q,
    output logic [1:0]                     extTraceLevel_q,
    output logic [1:0]                     extPerfLevel_q,
    // Trace permission
    input  wire logic                      inRootState,
    input  wire logic                      inRealmState,
    input  wire logic                      traceAuthOverride,
    output logic                           traceProhibit_q,
    output logic [1:0]                     traceAuthLevel_q
);
    import monitor_regs_pkg::*;

    // Writable bits of the configuration register, by feature
    function automatic logic [CFG_W-1:0] cfg_mask();
        logic [CFG_W-1:0] m;
        m = '0;
        m[PERF_TRAP_BIT]  = PERF_MON_FEATURE;
        m[DBG_EXT_BIT]    = REALM_MGMT_FEATURE;
        m[TRC_EXT_BIT]    = REALM_MGMT_FEATURE && EXT_TRACE_IF &&
                            TRACE_BUFFER_FEATURE;
        m[PERF_EXT_BIT]   = REALM_MGMT_FEATURE && PERF_MON_FEATURE &&
                            EXT_PERF_IF;
        m[ROOT_TRACE_BIT] = REALM_MGMT_FEATURE && TRACE_FILTER_FEATURE;
        m[REALM_TRC_BIT]  = REALM_MGMT_FEATURE && TRACE_FILTER_FEATURE;
        return m;
    endfunction

    // Implemented address bits 51:12, zero past the physical width
    function automatic logic [FA_PA_W-1:0] pa_mask();
        logic [FA_PA_W-1:0] m;
        m = '0;
        for (int i = 0; i < FA_PA_W; i++) begin
            m[i] = ((i + FA_PA_LO) < PA_WIDTH) &&
                   ((i + FA_PA_LO) <= FA_PA_HI || LARGE_PA_FEATURE);
        end
        return m;
    endfunction

    // Exception class for a trapped performance monitor access
    function automatic logic [5:0] trap_class(pmu_acc_t form);
        logic [5:0] c;
        case (form)
            ACC_SYS64:  c = EC_SYSREG64;
            ACC_MOVE32: c = EC_MOVE32;
            ACC_MOVE2X: c = EC_MOVE2X;
            default:    c = EC_SYSREG64;
        endcase
        return c;
    endfunction

    localparam logic [CFG_W-1:0]   CFG_MASK = cfg_mask();
    localparam logic [FA_PA_W-1:0] PA_MASK  = pa_mask();

    logic [CFG_W-1:0]   cfg_q;
    logic [CFG_W-1:0]   cfg_d;
    logic [FA_PA_W-1:0] faAddr_q;
    logic [FA_PA_W-1:0] faAddr_d;
    logic               faNs_q;
    logic               faNs_d;
    logic               faNse_q;
    logic               faNse_d;

    // Access decode
    wire hitCfg;
    wire hitFault;
    wire accUndef;

    sysreg_decode #(
        .REALM_MGMT_FEATURE (REALM_MGMT_FEATURE)
    ) u_decode (
        .valid    (regReq),
        .enc      (regEnc),
        .level    (regLevel),
        .hitCfg   (hitCfg),
        .hitFault (hitFault),
        .undef    (accUndef)
    );

    wire cfgWr   = hitCfg && regWrite;
    wire faultWr = hitFault && regWrite;
    wire claimed = hitCfg || hitFault || accUndef;

    // Read views, reserved and absent bits forced to zero
    wire [CFG_W-1:0] cfgView = cfg_q & CFG_MASK;
    wire [63:0] cfgRead = {{(64 - CFG_W){1'b0}}, cfgView};
    wire [FA_PA_W-1:0] faView = faAddr_q & PA_MASK;
    // address space in top two bits
    // bits 61:52 and 11:0 read zero
    wire [63:0] faRead = {faNs_q, faNse_q,
                          {(FA_NSE_BIT - FA_LPA_HI - 1){1'b0}},
                          faView,
                          {FA_PA_LO{1'b0}}};
    wire [63:0] rdSel = hitCfg   ? cfgRead :
                        hitFault ? faRead  : 64'h0;

    // trap bit kept only with a monitor unit
    assign cfg_d = cfgWr ? (regWdata[CFG_W-1:0] & CFG_MASK) : cfg_q;

    // Fault capture beats software write and exception return
    wire [FA_PA_W-1:0] wrAddr = regWdata[FA_LPA_HI:FA_PA_LO];
    wire [FA_PA_W-1:0] hwAddr = gpcAddr[FA_LPA_HI:FA_PA_LO];
    wire faCapture = gpcFault && REALM_MGMT_FEATURE;

    // return at monitor level discards contents
    assign faAddr_d = faCapture ? (hwAddr & PA_MASK) :
                      faultWr   ? (wrAddr & PA_MASK) :
                      monEret   ? FA_PA_RESET        : faAddr_q;
    // space bits captured with the address
    assign faNs_d   = faCapture ? gpcNonSecure :
                      faultWr   ? regWdata[FA_NS_BIT] :
                      monEret   ? 1'b0 : faNs_q;
    assign faNse_d  = faCapture ? gpcSpaceExt :
                      faultWr   ? regWdata[FA_NSE_BIT] :
                      monEret   ? 1'b0 : faNse_q;

    // Performance monitor trap decision
    wire perfTrapOn = cfgView[PERF_TRAP_BIT];
    wire lowerLevel = (pmuLevel != LVL_MON);
    wire trapNow = pmuReq && perfTrapOn && lowerLevel && !hypPerfTrap;
    wire [5:0] classNow = trapNow ? trap_class(pmuForm) : EC_NONE;

    // External debugger restriction levels, {extension, companion}
    // breakpoint, watchpoint and lock registers
    wire [1:0] dbgLvl  = {cfgView[DBG_EXT_BIT], extDebugAccessDisable};
    wire [1:0] trcLvl  = {cfgView[TRC_EXT_BIT], extTraceAccessDisable};
    wire [1:0] perfLvl = {cfgView[PERF_EXT_BIT], extPerfAccessDisable};

    // Trace permission for the current security state
    // root trace needs bit 1 or override
    wire rootBlock  = inRootState && !cfgView[ROOT_TRACE_BIT] &&
                      !traceAuthOverride;
    // realm trace needs bit 0 or override
    wire realmBlock = inRealmState && !cfgView[REALM_TRC_BIT] &&
                      !traceAuthOverride;
    wire [1:0] authLvl = {cfgView[ROOT_TRACE_BIT], cfgView[REALM_TRC_BIT]};

    // Next values of the answer and status flops
    logic        regAck_d;
    logic        regUndef_d;
    logic        regClaim_d;
    logic [63:0] regRdata_d;
    logic        pmuDone_d;
    logic        pmuTrap_d;
    logic [5:0]  pmuClass_d;
    logic [1:0]  extDebugLevel_d;
    logic [1:0]  extTraceLevel_d;
    logic [1:0]  extPerfLevel_d;
    logic        traceProhibit_d;
    logic [1:0]  traceAuthLevel_d;

    assign regAck_d   = regReq;
    assign regUndef_d = accUndef;
    assign regClaim_d = claimed;
    // Writes and refused reads answer zero, no stale word leaks
    assign regRdata_d = (regReq && !regWrite) ? rdSel : 64'h0;

    assign pmuDone_d  = pmuReq;
    assign pmuTrap_d  = trapNow;
    // Class reads zero whenever no trap is taken
    assign pmuClass_d = classNow;

    // Restriction combination, its meaning decoded outside
    assign extDebugLevel_d  = dbgLvl;
    assign extTraceLevel_d  = trcLvl;
    assign extPerfLevel_d   = perfLvl;
    assign traceProhibit_d  = rootBlock || realmBlock;
    assign traceAuthLevel_d = authLvl;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cfg_q <= CFG_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // Unknown reset value taken as zero
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            faAddr_q <= FA_PA_RESET;
        end else begin
            faAddr_q <= faAddr_d;
        end
    end

    // Space bits start at Secure after reset
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            faNs_q  <= 1'b0;
            faNse_q <= 1'b0;
        end else begin
            faNs_q  <= faNs_d;
            faNse_q <= faNse_d;
        end
    end

    // Access answer, one cycle after the request
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            regAck_q   <= 1'b0;
            regUndef_q <= 1'b0;
            regClaim_q <= 1'b0;
        end else begin
            regAck_q   <= regAck_d;
            regUndef_q <= regUndef_d;
            regClaim_q <= regClaim_d;
        end
    end

    // Read word stands with the acknowledge
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            regRdata_q <= 64'h0;
        end else begin
            regRdata_q <= regRdata_d;
        end
    end

    // Trap answer, one cycle after the check request
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pmuDone_q <= 1'b0;
            pmuTrap_q <= 1'b0;
        end else begin
            pmuDone_q <= pmuDone_d;
            pmuTrap_q <= pmuTrap_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pmuClass_q <= EC_NONE;
        end else begin
            pmuClass_q <= pmuClass_d;
        end
    end

    // Status levels follow the register a cycle later
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            extDebugLevel_q <= 2'h0;
            extTraceLevel_q <= 2'h0;
            extPerfLevel_q  <= 2'h0;
        end else begin
            extDebugLevel_q <= extDebugLevel_d;
            extTraceLevel_q <= extTraceLevel_d;
            extPerfLevel_q  <= extPerfLevel_d;
        end
    end

    // Trace permission and authentication level
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            traceProhibit_q  <= 1'b0;
            traceAuthLevel_q <= 2'h0;
        end else begin
            traceProhibit_q  <= traceProhibit_d;
            traceAuthLevel_q <= traceAuthLevel_d;
        end
    end

endmodule

// ---- monitor_debug_regs_properties.sv ----
// Property checker for the monitor debug register block.
// Assumes a bind to monitor_debug_regs; sees its ports only.
`timescale 1ns/1ps
module monitor_debug_regs_properties
    import monitor_regs_pkg::*;
(
    input wire logic                       clk_sys,
    input wire logic                       nrst,
    input wire logic                       regReq,
    input wire logic                       regWrite,
    input wire logic [15:0]                regEnc,
    input wire monitor_regs_pkg::level_t   regLevel,
    input wire logic                       regAck_q,
    input wire logic                       regUndef_q,
    input wire logic                       regClaim_q,
    input wire logic [63:0]                regRdata_q,
    input wire logic                       pmuReq,
    input wire monitor_regs_pkg::level_t   pmuLevel,
    input wire monitor_regs_pkg::pmu_acc_t pmuForm,
    input wire logic                       hypPerfTrap,
    input wire logic                       pmuDone_q,
    input wire logic                       pmuTrap_q,
    input wire logic [5:0]                 pmuClass_q,
    input wire logic                       gpcFault,
    input wire logic [51:0]                gpcAddr,
    input wire logic                       gpcNonSecure,
    input wire logic                       gpcSpaceExt,
    input wire logic                       monEret
);
    logic [63:0] expFa_q;
    wire         rdFa;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    assign rdFa = regReq && !regWrite && regEnc == ENC_FA
                  && regLevel == LVL_MON;

    // Independent copy of what a capture should leave behind
    always_ff @(posedge clk_sys) begin
        if (gpcFault) begin
            expFa_q <= {gpcNonSecure, gpcSpaceExt, 10'h000,
                        gpcAddr[51:12], 12'h000};
        end
    end

    a_ack_next: assert property (regReq |=> regAck_q)
        else $error("access not answered next cycle");
    a_ack_cause: assert property (regAck_q |-> $past(regReq))
        else $error("answer without a request");
    a_low_undef: assert property (regReq && regLevel != LVL_MON
        && (regEnc == ENC_CFG || regEnc == ENC_FA) |=> regUndef_q)
        else $error("lower level access not refused");
    a_cfg_zero: assert property (regReq && regEnc == ENC_CFG
        |=> regRdata_q[63:7] == '0 && !regRdata_q[5])
        else $error("config reserved bits not zero");
    a_fa_zero: assert property (regReq && regEnc == ENC_FA
        |=> regRdata_q[61:52] == 10'h000 && regRdata_q[11:0] == 12'h000)
        else $error("fault reserved bits not zero");
    a_fa_capture: assert property (gpcFault ##1
        (rdFa && !gpcFault && !monEret) |=> regRdata_q == expFa_q)
        else $error("captured fault address wrong");
    a_eret_clear: assert property (monEret && !gpcFault
        ##1 (rdFa && !gpcFault) |=> regRdata_q == 64'h0)
        else $error("fault register kept after return");
    a_trap_class: assert property (pmuDone_q && pmuTrap_q
        |-> pmuClass_q == ($past(pmuForm) == ACC_SYS64 ? EC_SYSREG64 :
        $past(pmuForm) == ACC_MOVE32 ? EC_MOVE32 : EC_MOVE2X))
        else $error("trap class wrong for access form");
    a_no_trap: assert property (pmuReq && (hypPerfTrap
        || pmuLevel == LVL_MON) |=> pmuDone_q && !pmuTrap_q)
        else $error("monitor trap taken when not due");
    a_unclaimed: assert property (regAck_q && !regClaim_q
        |-> regRdata_q == 64'h0)
        else $error("foreign encoding returned data");

    c_trap: cover property (pmuDone_q && pmuTrap_q);
    c_undef: cover property (regAck_q && regUndef_q);
    c_capture: cover property (gpcFault ##1 rdFa);
endmodule

bind monitor_debug_regs monitor_debug_regs_properties chk (
    .clk_sys, .nrst, .regReq, .regWrite, .regEnc, .regLevel, .regAck_q,
    .regUndef_q, .regClaim_q, .regRdata_q, .pmuReq, .pmuLevel, .pmuForm,
    .hypPerfTrap, .pmuDone_q, .pmuTrap_q, .pmuClass_q, .gpcFault,
    .gpcAddr, .gpcNonSecure, .gpcSpaceExt, .monEret
);

// ---- monitor_debug_regs_tb.sv ----
// Self-checking bench for the monitor debug register block.
// Assumes default feature parameters for dut, realm and monitor unit absent in dutBare.
`timescale 1ns/1ps
module monitor_debug_regs_tb;
    import monitor_regs_pkg::*;
    logic        clk_sys = 1'h0, nrst = 1'h0, regReq = 1'h0;
    logic        regWrite = 1'h0, pmuReq = 1'h0, hypPerfTrap = 1'h0;
    logic [15:0] regEnc = 16'h0;
    logic [63:0] regWdata = 64'h0, rd;
    level_t      regLevel = LVL_USER, pmuLevel = LVL_USER;
    pmu_acc_t    pmuForm = ACC_SYS64;
    logic        gpcFault = 1'h0, gpcNonSecure = 1'h0, gpcSpaceExt = 1'h0;
    logic [51:0] gpcAddr = 52'h0;
    logic        monEret = 1'h0, inRootState = 1'h0, inRealmState = 1'h0;
    logic        extDebugAccessDisable = 1'h0, traceAuthOverride = 1'h0;
    logic        extTraceAccessDisable = 1'h0, extPerfAccessDisable = 1'h0;
    logic        regAck_q, regUndef_q, regClaim_q, pmuDone_q, pmuTrap_q;
    logic        traceProhibit_q, ud, cl;
    logic [63:0] regRdata_q;
    logic [5:0]  pmuClass_q;
    logic [1:0]  extDebugLevel_q, extTraceLevel_q, extPerfLevel_q;
    logic [1:0]  traceAuthLevel_q;
    int          n_fail = 0, comparisons = 0;
    logic        bareUndef, bareClaim, bareTrap;
    logic [63:0] bareRdata;
    logic [1:0]  bareDbgLevel, bareAuthLevel;

    monitor_debug_regs dut (
        .clk_sys, .nrst, .regReq, .regWrite, .regEnc, .regLevel, .regWdata,
        .regAck_q, .regUndef_q, .regClaim_q, .regRdata_q, .pmuReq,
        .pmuLevel, .pmuForm, .hypPerfTrap, .pmuDone_q, .pmuTrap_q,
        .pmuClass_q, .gpcFault, .gpcAddr, .gpcNonSecure, .gpcSpaceExt,
        .monEret, .extDebugAccessDisable, .extTraceAccessDisable,
        .extPerfAccessDisable, .extDebugLevel_q, .extTraceLevel_q,
        .extPerfLevel_q, .inRootState, .inRealmState, .traceAuthOverride,
        .traceProhibit_q, .traceAuthLevel_q
    );

    // Copy without realm and monitor unit; its capture path is dead
    monitor_debug_regs #(
        .PERF_MON_FEATURE   (1'b0),
        .REALM_MGMT_FEATURE (1'b0)
    ) dutBare (
        .clk_sys, .nrst, .regReq, .regWrite, .regEnc, .regLevel, .regWdata,
        .regAck_q         (),
        .regUndef_q       (bareUndef),
        .regClaim_q       (bareClaim),
        .regRdata_q       (bareRdata),
        .pmuReq, .pmuLevel, .pmuForm, .hypPerfTrap,
        .pmuDone_q        (),
        .pmuTrap_q        (bareTrap),
        .pmuClass_q       (),
        .gpcFault         (1'h0),
        .gpcAddr, .gpcNonSecure, .gpcSpaceExt, .monEret,
        .extDebugAccessDisable, .extTraceAccessDisable, .extPerfAccessDisable,
        .extDebugLevel_q  (bareDbgLevel),
        .extTraceLevel_q  (),
        .extPerfLevel_q   (),
        .inRootState, .inRealmState, .traceAuthOverride,
        .traceProhibit_q  (),
        .traceAuthLevel_q (bareAuthLevel)
    );

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One register access; request held for a single cycle
    task automatic acc(input logic wr, input logic [15:0] enc,
                       input level_t lv, input logic [63:0] wd);
        int i;
        @(negedge clk_sys);
        regWrite = wr;
        regEnc   = enc;
        regLevel = lv;
        regWdata = wd;
        regReq   = 1'h1;
        @(negedge clk_sys);
        regReq = 1'h0;
        for (i = 0; i < 4 && regAck_q !== 1'h1; i++) begin
            @(negedge clk_sys);
        end
        if (regAck_q !== 1'h1) begin
            n_fail++;
            test_done();
        end
        rd = regRdata_q;
        ud = regUndef_q;
        cl = regClaim_q;
    endtask

    task automatic pmu(input level_t lv, input pmu_acc_t f, input logic hyp,
                       input logic trap, input logic [5:0] cls);
        @(negedge clk_sys);
        pmuLevel    = lv;
        pmuForm     = f;
        hypPerfTrap = hyp;
        pmuReq      = 1'h1;
        @(negedge clk_sys);
        pmuReq = 1'h0;
        check(64'({pmuDone_q, pmuTrap_q, pmuClass_q}),
              64'({1'h1, trap, cls}));
    endtask

    task automatic t_cfg;
        acc(1'h0, ENC_CFG, LVL_MON, 64'h0);
        check(rd, 64'h0);
        acc(1'h1, ENC_CFG, LVL_MON, 64'hffff_ffff_ffff_ffff);
        acc(1'h0, ENC_CFG, LVL_MON, 64'h0);
        check(rd, 64'h5f);
        check(64'(traceAuthLevel_q), 64'h3);
        inRootState = 1'h1;
        extDebugAccessDisable = 1'h1;
        extPerfAccessDisable = 1'h1;
        repeat (2) @(negedge clk_sys);
        check(64'(traceProhibit_q), 64'h0);
        check(64'({extDebugLevel_q, extTraceLevel_q, extPerfLevel_q}),
              64'h3b);
        acc(1'h1, ENC_CFG, LVL_MON, 64'h40);
        repeat (2) @(negedge clk_sys);
        check(64'(traceProhibit_q), 64'h1);
        check(64'(traceAuthLevel_q), 64'h0);
        traceAuthOverride = 1'h1;
        repeat (2) @(negedge clk_sys);
        check(64'(traceProhibit_q), 64'h0);
        traceAuthOverride = 1'h0;
        inRootState = 1'h0;
        inRealmState = 1'h1;
        repeat (2) @(negedge clk_sys);
        check(64'(traceProhibit_q), 64'h1);
        check(64'(extDebugLevel_q), 64'h1);
    endtask

    task automatic t_undef;
        for (int l = 0; l < 3; l++) begin
            acc(1'h1, ENC_CFG, level_t'(l), 64'hffff_ffff_ffff_ffff);
            check(64'(ud), 64'h1);
            acc(1'h0, ENC_FA, level_t'(l), 64'h0);
            check(64'(ud), 64'h1);
        end
        acc(1'h0, ENC_CFG, LVL_MON, 64'h0);
        check(rd, 64'h40);
        acc(1'h0, 16'h1234, LVL_MON, 64'h0);
        check(64'({cl, ud}), 64'h0);
        check(rd, 64'h0);
    endtask

    task automatic t_pmu;
        pmu(LVL_KERNEL, ACC_SYS64, 1'h0, 1'h1, EC_SYSREG64);
        pmu(LVL_USER, ACC_MOVE32, 1'h0, 1'h1, EC_MOVE32);
        pmu(LVL_HYP, ACC_MOVE2X, 1'h0, 1'h1, EC_MOVE2X);
        pmu(LVL_MON, ACC_SYS64, 1'h0, 1'h0, EC_NONE);
        pmu(LVL_KERNEL, ACC_MOVE32, 1'h1, 1'h0, EC_NONE);
        acc(1'h1, ENC_CFG, LVL_MON, 64'h0);
        pmu(LVL_USER, ACC_SYS64, 1'h0, 1'h0, EC_NONE);
    endtask

    task automatic t_fault;
        for (int s = 0; s < 4; s++) begin
            gpcAddr = 52'h9_8765_4321_0fed + 52'(s << 12);
            {gpcSpaceExt, gpcNonSecure} = 2'(s);
            gpcFault = 1'h1;
            fork
                @(negedge clk_sys) gpcFault = 1'h0;
            join_none
            acc(1'h0, ENC_FA, LVL_MON, 64'h0);
            check(rd, {gpcNonSecure, gpcSpaceExt, 10'h000, gpcAddr[51:12],
                       12'h000});
        end
        monEret = 1'h1;
        fork
            @(negedge clk_sys) monEret = 1'h0;
        join_none
        acc(1'h0, ENC_FA, LVL_MON, 64'h0);
        check(rd, 64'h0);
        acc(1'h1, ENC_FA, LVL_MON, 64'hffff_ffff_ffff_ffff);
        acc(1'h0, ENC_FA, LVL_MON, 64'h0);
        check(rd, 64'hc00f_ffff_ffff_f000);
    endtask

    task automatic t_absent;
        acc(1'h1, ENC_CFG, LVL_MON, 64'hffff_ffff_ffff_ffff);
        acc(1'h0, ENC_CFG, LVL_MON, 64'h0);
        check(bareRdata, 64'h0);
        check(rd, 64'h5f);
        check(64'(bareDbgLevel), 64'h1);
        check(64'(bareAuthLevel), 64'h0);
        pmu(LVL_KERNEL, ACC_SYS64, 1'h0, 1'h1, EC_SYSREG64);
        check(64'(bareTrap), 64'h0);
        acc(1'h0, ENC_FA, LVL_MON, 64'h0);
        check(64'({bareClaim, bareUndef}), 64'h3);
        check(bareRdata, 64'h0);
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        nrst = 1'h1;
        t_cfg();
        t_undef();
        t_pmu();
        t_fault();
        t_absent();
        test_done();
    end
endmodule
